//--- dv/ceau_checker.sv
module ceau_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hresp,
  input wire logic hreadyout,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [7:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic next_instr_go
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // slave never stalls and never errors
  a_bus_okay: assert property (!hresp && hreadyout)
    else $error("bus response not okay and ready");
  // request, its address and its direction stand until acknowledged
  a_req_hold: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request dropped or changed early");
  // a byte read in a move is followed by writing that byte
  a_copy_byte: assert property (mem_req && !mem_we && mem_ack &&
    mem_size == 2'h0 |=> mem_req && mem_we &&
    mem_wdata == $past(mem_rdata[7:0]))
    else $error("copied byte differs from byte read");
  a_move_size: assert property (mem_req && mem_we |->
    mem_size == 2'h0)
    else $error("block move write is not byte sized");
  // after a write lands: either done or the next read at once
  a_move_next: assert property (mem_req && mem_we && mem_ack |=>
    next_instr_go ^ (mem_req && !mem_we))
    else $error("no prompt continuation after byte written");
  a_go_pulse: assert property (next_instr_go |=> !next_instr_go)
    else $error("completion pulse longer than one cycle");
  a_go_quiet: assert property (next_instr_go |-> !mem_req)
    else $error("completion while memory still busy");
  // indirect pointer fetch stays in the first 256 bytes, even
  a_ind_range: assert property (mem_req && mem_size == 2'h2 |->
    mem_addr[31:8] == 24'h00_0000 && !mem_addr[0])
    else $error("indirect fetch outside low page");
  cover property (mem_req && mem_we && mem_ack ##1 next_instr_go);
endmodule

bind ceau_top ceau_checker u_chk (.hclk, .hresetn, .hresp, .hreadyout,
  .mem_req, .mem_we, .mem_addr, .mem_size, .mem_wdata, .mem_rdata,
  .mem_ack, .next_instr_go);

//--- dv/ceau_mem_model.sv
module ceau_mem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [7:0] mem_wdata,
  input wire logic [3:0] lag,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:1023];
  logic [9:0] a;
  int cnt;
  assign a = mem_addr[9:0];
  // lag adds wait cycles; data lines flip when not answering so
  // a late sample never sees a stale but plausible value
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      cnt <= 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (cnt < int'(lag)) begin
          cnt <= cnt + 1;
        end else begin
          cnt <= 0;
          mem_ack <= 1'b1;
          if (mem_we) begin
            mem[a] <= mem_wdata;
          end else if (mem_size == 2'h2) begin
            mem_rdata <= {mem[a], mem[a+1], mem[a+2], mem[a+3]};
          end else begin
            mem_rdata <= {24'h00_0000, mem[a]};
          end
        end
      end
    end
  end
endmodule

//--- dv/tb_cpu_effective_address_unit.sv
module tb_cpu_effective_address_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import ceau_pkg::*;
  typedef struct packed {
    logic [3:0] md;
    logic [1:0] xw;
    logic [15:0] op;
    logic [31:0] ext;
    logic [7:0] ctl;
    logic [31:0] ea;
  } ceau_case_t;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, mem_addr, mem_rdata;
  logic [1:0] htrans = 0, mem_size;
  logic mem_req, mem_we, mem_ack, next_instr_go;
  logic [7:0] mem_wdata;
  logic [3:0] lag = 0;
  logic [31:0] x;
  int bad_count = 0, tests_run = 0;
  // base register 32'hab12_3457, pc 32'h1000
  ceau_case_t cases [14] = '{
    '{4'h1, 2'd0, 16'h0000, 32'h0, 8'h01, 32'hab12_3457},
    '{4'h1, 2'd0, 16'h0000, 32'h0, 8'h09, 32'h0012_3456},
    '{4'h2, 2'd1, 16'h0000, 32'hfff0, 8'h01, 32'hab12_3447},
    '{4'h3, 2'd2, 16'h0000, 32'h10, 8'h01, 32'hab12_3467},
    '{4'h4, 2'd0, 16'h0000, 32'h0, 8'h21, 32'hab12_3456},
    '{4'h5, 2'd0, 16'h0000, 32'h0, 8'h11, 32'hab12_3454},
    '{4'h6, 2'd0, 16'h0034, 32'h0, 8'h01, 32'hffff_ff34},
    '{4'h7, 2'd1, 16'h0000, 32'h8002, 8'h01, 32'hffff_8002},
    '{4'h7, 2'd1, 16'h0000, 32'h7fff, 8'h01, 32'h0000_7fff},
    '{4'h8, 2'd2, 16'h0000, 32'hff12_3457, 8'h01, 32'h0012_3456},
    '{4'h9, 2'd2, 16'h0000, 32'hfedc_ba99, 8'h01, 32'hfedc_ba99},
    '{4'hb, 2'd0, 16'h00f0, 32'h0, 8'h01, 32'h0000_0ff2},
    '{4'hc, 2'd1, 16'h0000, 32'h0100, 8'h01, 32'h0000_1104},
    '{4'hd, 2'd0, 16'h0010, 32'h0, 8'h01, 32'h0012_3456}};

  always #12.5 hclk = ~hclk;

  ceau_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .mem_req, .mem_we, .mem_addr, .mem_size, .mem_wdata,
    .mem_rdata, .mem_ack, .next_instr_go);
  ceau_mem_model u_mem (.hclk, .hresetn, .mem_req, .mem_we, .mem_addr,
    .mem_size, .mem_wdata, .lag, .mem_rdata, .mem_ack);

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one single word transfer; entered just after a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    x = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  // completion pulse, bounded wait
  task wait_go;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (next_instr_go !== 1'b1 && n < 400);
    chk({31'h0, next_instr_go}, 32'h0000_0001);
  endtask

  task calc(input ceau_case_t c, input logic [31:0] base);
    for (int i = 0; i < 8; i++) wr(OFS_GPR0 + 8'(4 * i), base);
    wr(OFS_OPWORD, {16'h0000, c.op});
    wr(OFS_EXT, c.ext);
    wr(OFS_MODE, {26'h0, c.xw, c.md});
    wr(OFS_PC, 32'h0000_1000);
    wr(OFS_CTRL, {24'h00_0000, c.ctl});
    wait_go;
  endtask

  task close_out;
    $display("checks=%0d errors=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog, far beyond the thousand or so cycles the run needs
  initial begin
    repeat (40000) @(posedge hclk);
    bad_count++;
    close_out;
  end

  initial begin
    {u_mem.mem[16], u_mem.mem[17]} = 16'h5a12;
    {u_mem.mem[18], u_mem.mem[19]} = 16'h3457;
    {u_mem.mem[256], u_mem.mem[257], u_mem.mem[258]} = 24'h11_2233;
    {u_mem.mem[259], u_mem.mem[260]} = 16'h4455;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFS_CTRL);
    chk(x, 32'h0000_0000);
    wr(8'h30, 32'hffff_ffff);
    rd(8'h30);
    chk(x, 32'h0000_0000);
    rd(OFS_STATUS);
    chk(x, 32'h0000_0000);
    // address modes, next pc counts whole 16-bit words
    foreach (cases[i]) begin
      calc(cases[i], 32'hab12_3457);
      rd(OFS_EA);
      chk(x, cases[i].ea);
      rd(OFS_NEXTPC);
      chk(x, 32'h1002 + 32'(2 * cases[i].xw));
      rd(OFS_WBACK);
      if (cases[i].md == 4'h4) chk(x, 32'hab12_345b);
      if (cases[i].md == 4'h5) chk(x, 32'hab12_3455);
    end
    calc('{4'h0, 2'd0, 16'ha5b6, 32'h0, 8'h01, 32'h0}, 32'h0);
    rd(OFS_DECODE);
    chk(x, 32'h000f_a536);
    // bit number taken from the register named by the second field
    calc('{4'h0, 2'd0, 16'h0500, 32'h0, 8'h81, 32'h0}, 32'h0000_0005);
    rd(OFS_DECODE);
    chk(x & 32'h001c_0000, 32'h0014_0000);
    // register direct picks a part, immediates pass through unchanged
    calc('{4'h0, 2'd0, 16'h0000, 32'h0, 8'h01, 32'h0}, 32'hab12_3457);
    rd(OFS_OPERAND);
    chk(x, 32'h0000_0034);
    calc('{4'h0, 2'd0, 16'h0008, 32'h0, 8'h11, 32'h0}, 32'hab12_3457);
    rd(OFS_OPERAND);
    chk(x, 32'h0000_ab12);
    calc('{4'ha, 2'd0, 16'h00c3, 32'h0, 8'h01, 32'h0}, 32'h0);
    rd(OFS_OPERAND);
    chk(x, 32'h0000_00c3);
    calc('{4'ha, 2'd1, 16'h0000, 32'hfedc_ba98, 8'h01, 32'h0}, 32'h0);
    rd(OFS_OPERAND);
    chk(x, 32'h0000_ba98);
    calc('{4'ha, 2'd2, 16'h0000, 32'hfedc_ba98, 8'h01, 32'h0}, 32'h0);
    rd(OFS_OPERAND);
    chk(x, 32'hfedc_ba98);
    // bit operation on a displacement operand is refused
    calc('{4'h2, 2'd1, 16'h0000, 32'h4, 8'h41, 32'h0}, 32'h0);
    rd(OFS_STATUS);
    chk(x & 32'h6, 32'h6);
    wr(OFS_STATUS, 32'h6);
    calc('{4'h1, 2'd0, 16'h0000, 32'h0, 8'h41, 32'h0}, 32'h0);
    rd(OFS_STATUS);
    chk(x & 32'h4, 32'h0);
    // byte-count move, slow memory, upper count bits kept
    lag <= 4'h2;
    wr(OFS_GPR0 + 8'h10, 32'hffff_ff03);
    wr(OFS_GPR0 + 8'h14, 32'h0000_0100);
    wr(OFS_GPR0 + 8'h18, 32'h0000_0200);
    wr(OFS_CTRL, 32'h0000_0002);
    wait_go;
    chk({8'h0, u_mem.mem[512], u_mem.mem[513], u_mem.mem[514]},
      32'h0011_2233);
    rd(OFS_GPR0 + 8'h10);
    chk(x, 32'hffff_ff00);
    rd(OFS_GPR0 + 8'h14);
    chk(x, 32'h0000_0103);
    rd(OFS_GPR0 + 8'h18);
    chk(x, 32'h0000_0203);
    // zero byte count does nothing
    wr(OFS_GPR0 + 8'h10, 32'h0000_ff00);
    wr(OFS_CTRL, 32'h0000_0002);
    wait_go;
    rd(OFS_STATUS);
    chk(x & 32'h8, 32'h8);
    rd(OFS_GPR0 + 8'h14);
    chk(x, 32'h0000_0103);
    // word-count move, prompt memory
    lag <= 4'h0;
    wr(OFS_GPR0 + 8'h10, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0006);
    wait_go;
    chk({16'h0, u_mem.mem[515], u_mem.mem[516]}, 32'h0000_4455);
    rd(OFS_GPR0 + 8'h10);
    chk(x, 32'h0000_0000);
    close_out;
  end
endmodule

//--- hw/ceau_pkg.sv
package ceau_pkg;
  // bus and datapath widths
  localparam int DW = 32;
  localparam int AW = 32;
  localparam int NGPR = 8;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_OPWORD = 8'h08;
  localparam logic [7:0] OFS_EXT = 8'h0c;
  localparam logic [7:0] OFS_MODE = 8'h10;
  localparam logic [7:0] OFS_PC = 8'h14;
  localparam logic [7:0] OFS_EA = 8'h18;
  localparam logic [7:0] OFS_OPERAND = 8'h1c;
  localparam logic [7:0] OFS_DECODE = 8'h20;
  localparam logic [7:0] OFS_NEXTPC = 8'h24;
  localparam logic [7:0] OFS_WBACK = 8'h28;
  localparam logic [7:0] OFS_GPR0 = 8'h40;
  localparam logic [7:0] OFS_GPR_END = 8'h5c;

  // control register fields
  localparam int CTRL_CALC = 0;
  localparam int CTRL_MOVE = 1;
  localparam int CTRL_MOVE_WORD = 2;
  localparam int CTRL_INSTR = 3;
  localparam int CTRL_SIZE_LO = 4;
  localparam int CTRL_BITOP = 6;
  localparam int CTRL_BITREG = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // status register fields, done and error clear by writing one
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
  localparam int ST_ZERO = 3;

  // mode register fields
  localparam int MODE_EXTW_LO = 4;

  // operand size codes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_HALF = 16'h0000;

  // effective address space kept on instruction addresses
  localparam logic [7:0] TOP_ZERO = 8'h00;
  localparam logic [23:0] SHORT_FILL = 24'hff_ffff;
  // the narrow address mode is absent on this device
  localparam logic ADDR16_MODE = 1'b0;

  typedef enum logic [3:0] {
    ceau_md_reg_dir = 4'b0000,
    ceau_md_reg_ind = 4'b0001,
    ceau_md_disp16 = 4'b0010,
    ceau_md_disp32 = 4'b0011,
    ceau_md_postinc = 4'b0100,
    ceau_md_predec = 4'b0101,
    ceau_md_abs8 = 4'b0110,
    ceau_md_abs16 = 4'b0111,
    ceau_md_abs24 = 4'b1000,
    ceau_md_abs32 = 4'b1001,
    ceau_md_imm = 4'b1010,
    ceau_md_pcrel8 = 4'b1011,
    ceau_md_pcrel16 = 4'b1100,
    ceau_md_mem_ind = 4'b1101
  } ceau_mode_t;

  typedef enum logic [2:0] {
    ceau_st_idle = 3'b000,
    ceau_st_calc = 3'b001,
    ceau_st_mind = 3'b010,
    ceau_st_bm_chk = 3'b011,
    ceau_st_bm_rd = 3'b100,
    ceau_st_bm_wr = 3'b101
  } ceau_state_t;
endpackage

//--- hw/ceau_top.sv
module ceau_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ceau_pkg::AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [ceau_pkg::DW-1:0] hwdata,
  input wire logic hready,
  output logic [ceau_pkg::DW-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic mem_req,
  output logic mem_we,
  output logic [ceau_pkg::AW-1:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [7:0] mem_wdata,
  input wire logic [ceau_pkg::DW-1:0] mem_rdata,
  input wire logic mem_ack,
  output logic next_instr_go
);
  import ceau_pkg::*;

  function automatic logic [31:0] sext8(input logic [7:0] v);
    sext8 = {{24{v[7]}}, v};
  endfunction

  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction

  function automatic logic [31:0] size_step(input logic [1:0] sz);
    case (sz)
      SZ_BYTE: size_step = 32'h0000_0001;
      SZ_WORD: size_step = 32'h0000_0002;
      default: size_step = 32'h0000_0004;
    endcase
  endfunction

  // bit 0 forced low on aligned data and on branch targets
  function automatic logic [31:0] align(input logic [31:0] a,
                                        input logic even);
    align = even ? {a[31:1], 1'b0} : a;
  endfunction

  ceau_state_t state_q;
  logic [31:0] gpr_q [NGPR];
  logic [7:0] ctrl_q;
  logic [15:0] opword_q;
  logic [31:0] ext_q;
  logic [5:0] mode_q;
  logic [31:0] pc_q;
  logic [31:0] ea_q;
  logic [31:0] operand_q;
  logic [31:0] nextpc_q;
  logic [31:0] wback_q;
  logic [2:0] bitnum_q;
  logic done_q;
  logic err_q;
  logic zero_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;

  // opcode word fields; size from control, mode and extension words from mode register
  logic [3:0] op_main;
  logic [3:0] op_second;
  logic [2:0] addr_reg;
  logic [3:0] data_reg;
  logic [2:0] bit_imm;
  logic [1:0] trap_vec;
  logic [1:0] op_size;
  logic [1:0] ext_words;
  ceau_mode_t mode;

  assign op_main = opword_q[15:12];
  assign op_second = opword_q[11:8];
  assign addr_reg = opword_q[6:4];
  assign data_reg = opword_q[3:0];
  assign bit_imm = opword_q[6:4];
  assign trap_vec = opword_q[5:4];
  assign op_size = ctrl_q[CTRL_SIZE_LO +: 2];
  assign ext_words = mode_q[MODE_EXTW_LO +: 2];
  assign mode = ceau_mode_t'(mode_q[3:0]);

  // bus address phase, accepted only when the bus is ready
  logic addr_ok;
  assign addr_ok = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  logic wr_ctrl;
  logic wr_status;
  logic wr_gpr;
  logic [2:0] wr_gpr_idx;
  logic idle;
  assign idle = (state_q == ceau_st_idle);
  assign wr_ctrl = wr_pend_q && (wr_addr_q == OFS_CTRL);
  assign wr_status = wr_pend_q && (wr_addr_q == OFS_STATUS);
  // software may not touch the general registers while a job runs
  assign wr_gpr = wr_pend_q && idle && (wr_addr_q >= OFS_GPR0) &&
                  (wr_addr_q <= OFS_GPR_END) && (wr_addr_q[1:0] == 2'b00);
  assign wr_gpr_idx = wr_addr_q[4:2];

  logic start_calc;
  logic start_move;
  assign start_calc = wr_ctrl && idle && hwdata[CTRL_CALC];
  assign start_move = wr_ctrl && idle && hwdata[CTRL_MOVE] &&
                      !hwdata[CTRL_CALC];

  // instruction words and configuration, frozen while busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RESET;
      opword_q <= RST_HALF;
      ext_q <= RST_WORD;
      mode_q <= 6'h00;
      pc_q <= RST_WORD;
    end else if (wr_pend_q && idle) begin
      case (wr_addr_q)
        OFS_CTRL: ctrl_q <= {hwdata[7:2], 2'b00};
        OFS_OPWORD: opword_q <= hwdata[15:0];
        OFS_EXT: ext_q <= hwdata;
        OFS_MODE: mode_q <= hwdata[5:0];
        OFS_PC: pc_q <= {TOP_ZERO, hwdata[23:1], 1'b0};
        default: ;
      endcase
    end
  end

  // selected registers and register direct operand
  logic [31:0] areg;
  logic [31:0] dreg;
  logic [31:0] direct_val;
  assign areg = gpr_q[addr_reg];
  assign dreg = gpr_q[data_reg[2:0]];

  always_comb begin
    case (op_size)
      SZ_BYTE: direct_val = {24'h00_0000,
                             data_reg[3] ? dreg[7:0] : dreg[15:8]};
      SZ_WORD: direct_val = {16'h0000,
                             data_reg[3] ? dreg[31:16] : dreg[15:0]};
      default: direct_val = dreg;
    endcase
  end

  // effective address arithmetic for one calculation
  logic [31:0] inst_len;
  logic [31:0] next_pc;
  logic [31:0] ea_d;
  logic [31:0] operand_d;
  logic [31:0] wback_d;
  logic wback_en;
  logic is_target;
  logic bit_bad;
  logic [31:0] pc_sum;
  logic [31:0] ea_fin;

  // length in bytes: opcode word plus extension words, two bytes each
  assign inst_len = {29'h0000_0000, ext_words, 1'b0} + 32'h0000_0002;
  assign next_pc = pc_q + inst_len;

  always_comb begin
    ea_d = RST_WORD;
    operand_d = RST_WORD;
    wback_d = areg;
    wback_en = 1'b0;
    is_target = ctrl_q[CTRL_INSTR];
    pc_sum = RST_WORD;
    case (mode)
      ceau_md_reg_dir: operand_d = direct_val;
      ceau_md_reg_ind: begin
        ea_d = areg;
        if (ctrl_q[CTRL_INSTR]) begin
          ea_d = {TOP_ZERO, areg[23:0]};
        end
      end
      ceau_md_disp16: ea_d = areg + sext16(ext_q[15:0]);
      ceau_md_disp32: ea_d = areg + ext_q;
      ceau_md_postinc: begin
        ea_d = areg;
        wback_d = areg + size_step(op_size);
        wback_en = 1'b1;
      end
      ceau_md_predec: begin
        ea_d = areg - size_step(op_size);
        wback_d = ea_d;
        wback_en = 1'b1;
      end
      ceau_md_abs8: ea_d = {SHORT_FILL, opword_q[7:0]};
      ceau_md_abs16: ea_d = sext16(ext_q[15:0]);
      ceau_md_abs24: begin
        ea_d = {TOP_ZERO, ext_q[23:0]};
        is_target = 1'b1;
      end
      ceau_md_abs32: ea_d = ext_q;
      ceau_md_imm: begin
        case (ext_words)
          2'h0: operand_d = {24'h00_0000, opword_q[7:0]};
          2'h1: operand_d = {16'h0000, ext_q[15:0]};
          default: operand_d = ext_q;
        endcase
      end
      ceau_md_pcrel8: begin
        pc_sum = next_pc + sext8(opword_q[7:0]);
        ea_d = {TOP_ZERO, pc_sum[23:0]};
        is_target = 1'b1;
      end
      ceau_md_pcrel16: begin
        pc_sum = next_pc + sext16(ext_q[15:0]);
        ea_d = {TOP_ZERO, pc_sum[23:0]};
        is_target = 1'b1;
      end
      ceau_md_mem_ind: begin
        ea_d = {24'h00_0000, opword_q[7:0]};
        is_target = 1'b1;
      end
      default: ;
    endcase
  end

  // bit operations only reach direct, indirect or 8-, 16- or 32-bit absolute operands
  always_comb begin
    case (mode)
      ceau_md_reg_dir, ceau_md_reg_ind, ceau_md_abs8,
      ceau_md_abs16, ceau_md_abs32: bit_bad = 1'b0;
      default: bit_bad = ctrl_q[CTRL_BITOP];
    endcase
  end

  // alignment, then the narrow mode mask
  logic [31:0] ea_al;
  assign ea_al = align(ea_d, is_target || (op_size != SZ_BYTE));
  assign ea_fin = ADDR16_MODE ? {16'h0000, ea_al[15:0]} : ea_al;

  // block move counter view, byte or word form
  logic [15:0] move_count;
  logic move_word;
  assign move_word = ctrl_q[CTRL_MOVE_WORD];
  assign move_count = move_word ? gpr_q[4][15:0] :
                      {8'h00, gpr_q[4][7:0]};
  logic [15:0] count_dec;
  assign count_dec = move_count - 16'h0001;
  logic last_byte;
  assign last_byte = (state_q == ceau_st_bm_wr) && mem_ack &&
                     (count_dec == 16'h0000);

  // sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ceau_st_idle;
    end else begin
      case (state_q)
        ceau_st_idle: begin
          if (start_calc) begin
            state_q <= ceau_st_calc;
          end else if (start_move) begin
            state_q <= ceau_st_bm_chk;
          end
        end
        ceau_st_calc: begin
          if (mode == ceau_md_mem_ind && !bit_bad) begin
            state_q <= ceau_st_mind;
          end else begin
            state_q <= ceau_st_idle;
          end
        end
        ceau_st_mind: if (mem_ack) state_q <= ceau_st_idle;
        ceau_st_bm_chk: begin
          // a zero count moves nothing
          if (move_count == 16'h0000) begin
            state_q <= ceau_st_idle;
          end else begin
            state_q <= ceau_st_bm_rd;
          end
        end
        ceau_st_bm_rd: if (mem_ack) state_q <= ceau_st_bm_wr;
        ceau_st_bm_wr: begin
          if (mem_ack) begin
            state_q <= last_byte ? ceau_st_idle : ceau_st_bm_rd;
          end
        end
        default: state_q <= ceau_st_idle;
      endcase
    end
  end

  // general registers: hardware updates only while busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NGPR; i++) begin
        gpr_q[i] <= RST_WORD;
      end
    end else if (state_q == ceau_st_calc && wback_en && !bit_bad) begin
      gpr_q[addr_reg] <= wback_d;
    end else if (state_q == ceau_st_bm_wr && mem_ack) begin
      gpr_q[5] <= gpr_q[5] + 32'h0000_0001;
      gpr_q[6] <= gpr_q[6] + 32'h0000_0001;
      if (move_word) begin
        gpr_q[4][15:0] <= count_dec;
      end else begin
        gpr_q[4][7:0] <= count_dec[7:0];
      end
    end else if (wr_gpr) begin
      gpr_q[wr_gpr_idx] <= hwdata;
    end
  end

  // results of a calculation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ea_q <= RST_WORD;
      operand_q <= RST_WORD;
      nextpc_q <= RST_WORD;
      wback_q <= RST_WORD;
      bitnum_q <= 3'h0;
    end else if (state_q == ceau_st_calc) begin
      ea_q <= ea_fin;
      operand_q <= operand_d;
      nextpc_q <= next_pc;
      wback_q <= wback_d;
      // bit number from a register byte or from the opcode
      bitnum_q <= ctrl_q[CTRL_BITREG] ? gpr_q[op_second[2:0]][2:0] :
                  bit_imm;
    end else if (state_q == ceau_st_mind && mem_ack) begin
      ea_q <= align({TOP_ZERO, mem_rdata[23:0]}, 1'b1);
    end
  end

  // memory master: one request held until acknowledged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= RST_WORD;
      mem_size <= SZ_BYTE;
      mem_wdata <= 8'h00;
    end else begin
      if (mem_req && mem_ack) begin
        mem_req <= 1'b0;
      end
      if (state_q == ceau_st_calc && mode == ceau_md_mem_ind && !bit_bad) begin
        mem_req <= 1'b1;
        mem_we <= 1'b0;
        mem_addr <= ea_fin;
        mem_size <= SZ_LONG;
      end else if ((state_q == ceau_st_bm_chk && move_count != 16'h0000) ||
                   (state_q == ceau_st_bm_wr && mem_ack && !last_byte)) begin
        mem_req <= 1'b1;
        mem_we <= 1'b0;
        mem_size <= SZ_BYTE;
        mem_addr <= (state_q == ceau_st_bm_wr) ?
                    gpr_q[5] + 32'h0000_0001 : gpr_q[5];
      end else if (state_q == ceau_st_bm_rd && mem_ack) begin
        mem_req <= 1'b1;
        mem_we <= 1'b1;
        mem_size <= SZ_BYTE;
        mem_addr <= gpr_q[6];
        mem_wdata <= mem_rdata[7:0];
      end
    end
  end

  // completion flags; a new completion beats a clear in the same cycle
  logic calc_end;
  logic move_end;
  assign calc_end = (state_q == ceau_st_calc && !(mode == ceau_md_mem_ind &&
                     !bit_bad)) || (state_q == ceau_st_mind && mem_ack);
  assign move_end = last_byte ||
                    (state_q == ceau_st_bm_chk && move_count == 16'h0000);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
      err_q <= 1'b0;
      zero_q <= 1'b0;
      next_instr_go <= 1'b0;
    end else begin
      next_instr_go <= calc_end || move_end;
      if (calc_end || move_end) begin
        done_q <= 1'b1;
      end else if (wr_status && hwdata[ST_DONE]) begin
        done_q <= 1'b0;
      end
      if (state_q == ceau_st_calc && bit_bad) begin
        err_q <= 1'b1;
      end else if (wr_status && hwdata[ST_ERR]) begin
        err_q <= 1'b0;
      end
      if (state_q == ceau_st_bm_chk) begin
        zero_q <= (move_count == 16'h0000);
      end
    end
  end

  // read mux sampled at the address phase, so data is ready in the data phase
  logic [31:0] rd_val;
  logic [7:0] rd_ofs;
  assign rd_ofs = haddr[7:0];

  always_comb begin
    rd_val = RST_WORD;
    if (rd_ofs >= OFS_GPR0 && rd_ofs <= OFS_GPR_END) begin
      rd_val = gpr_q[rd_ofs[4:2]];
    end else begin
      case (rd_ofs)
        OFS_CTRL: rd_val = {24'h00_0000, ctrl_q};
        OFS_STATUS: rd_val = {28'h000_0000, zero_q, err_q, done_q, !idle};
        OFS_OPWORD: rd_val = {16'h0000, opword_q};
        OFS_EXT: rd_val = ext_q;
        OFS_MODE: rd_val = {26'h000_0000, mode_q};
        OFS_PC: rd_val = pc_q;
        OFS_EA: rd_val = ea_q;
        OFS_OPERAND: rd_val = operand_q;
        OFS_DECODE: rd_val = {11'h000, bitnum_q, trap_vec, op_main,
                              op_second, 1'b0, addr_reg, data_reg};
        OFS_NEXTPC: rd_val = nextpc_q;
        OFS_WBACK: rd_val = wback_q;
        default: rd_val = RST_WORD;
      endcase
    end
  end

  // zero wait states, always okay; hsize is not checked, words only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= RST_WORD;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok && !hwrite) begin
        hrdata <= rd_val;
      end
    end
  end
endmodule
